// file: design/arx_core.sv
// Functional notes
// - Full reset by hard reset pin held 1 us, or full reset command.
// - Full reset clears config, label memory, match values, all state.
// - Any reset aborts reception, drops partial words, empties status.
// - Any reset empties both receive FIFOs and clears all mailboxes.
// - Data-only reset keeps label memory, match values, configuration.
// - Reference clock divided to 1 MHz per programmed divider value.
// - Configuration is accepted at any time, regardless of activity.
// - Two receive channels, fully independent paths.
// - Deserialize 100k and 12-14.5k bit/s, two null bit gaps.
// - Sample line at ten times bit rate and filter before framing.
// - Accept legacy rates and gaps as short as two null bits.
// - Each framed word goes to FIFO filter and priority capture.
// - Parity on: odd count of ones stores 0 in bit 32.
// - Parity on: even count of ones stores 1 in bit 32.
// - Label filter on: drop words whose label entry is 0.
// - SDI filter on: drop mismatching SDI; load only if both pass.
// - 256 label accept bits loaded from label 0xff down to 0x00.
// - 32-word FIFO; word arriving when full overwrites the newest.
`timescale 1ns/1ps
module arx_core import arx_pkg::*; #(
   parameter int FIFO_DEPTH = ARX_FIFO_DEPTH,
   parameter int HR_CYC = ARX_HR_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Reset requests
   input wire logic hard_reset_pin,
   input wire logic full_reset,
   input wire logic data_only_reset,
   // Reference clock and divider setting
   input wire logic ref_clk_in,
   input wire logic clk_div_wr,
   input wire logic [3:0] clk_div_val,
   output logic [3:0] clk_div_rd,
   // Line receiver levels, one bit per channel
   input wire logic [1:0] rx_line_one,
   input wire logic [1:0] rx_line_zero,
   // Channel configuration, one bit per channel
   input wire logic [1:0] rx_low_speed,
   input wire logic [1:0] parity_enable,
   input wire logic [1:0] label_filter_enable,
   input wire logic [1:0] sdi_filter_enable,
   input wire logic [1:0] sdi_expected_high,
   input wire logic [1:0] sdi_expected_low,
   input wire logic [1:0] priority_label_capture,
   // Label filter memory load
   input wire logic lbl_load_start,
   input wire logic lbl_load_valid,
   input wire logic lbl_load_chan,
   input wire logic lbl_load_bit,
   // Priority label match values
   input wire logic pl_match_wr,
   input wire logic pl_match_chan,
   input wire logic [1:0] pl_match_idx,
   input wire logic [7:0] pl_match_val,
   // Priority mailbox read
   input wire logic mb_rd,
   input wire logic mb_rd_chan,
   input wire logic [1:0] mb_rd_idx,
   output logic mb_rd_valid,
   output logic [23:0] mb_rd_data,
   output logic [1:0][2:0] mb_avail,
   // Receive FIFO read and status
   input wire logic [1:0] fifo_rd,
   output logic [1:0] fifo_rd_valid,
   output arx_word_s [1:0] fifo_rd_data,
   output logic [1:0] fifo_empty,
   output logic [1:0] fifo_half,
   output logic [1:0] fifo_full,
   output logic [1:0] word_loaded
);

   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int CW = AW + 1;
   localparam int HW = $clog2(HR_CYC + 1);

   typedef struct packed {
      logic [HW-1:0] hr_cnt;
      logic [3:0] div;
      logic [1:0][ARX_LBL_NUM-1:0] lbl_mem;
      logic [7:0] lbl_ptr;
      logic [1:0][2:0][7:0] match;
      logic [1:0][2:0][23:0] mbox;
      logic [1:0][2:0] mb_avail;
      arx_word_s [1:0][FIFO_DEPTH-1:0] fifo;
      logic [1:0][AW-1:0] wp;
      logic [1:0][AW-1:0] rp;
      logic [1:0][CW-1:0] cnt;
      arx_word_s [1:0] rd_data;
      logic [1:0] rd_valid;
      logic [1:0] empty;
      logic [1:0] half;
      logic [1:0] full;
      logic [1:0] loaded;
      logic [23:0] mb_data;
      logic mb_valid;
   } arx_core_s;

   arx_core_s s, n;

   // Reset decode, used by the channel logic in the same cycle
   logic full_rst;
   logic data_rst;

   // Timing enables and framed words
   logic tick_1m;
   logic tick_low;
   logic [1:0] smp_en;
   logic [1:0] rx_valid;
   arx_word_s [1:0] rx_word;

   // Per-channel scratch of the update process
   arx_word_s w;
   logic label_hit;
   logic sdi_hit;
   logic load;
   logic do_rd;
   logic [CW-1:0] cnt_v;

   // Reference clock divider; a full reset restarts its counters
   arx_refdiv #(
      .LOW_DIV(ARX_LOW_SMP_DIV)
   ) u_refdiv (
      .clk(clk),
      .reset_n(reset_n),
      .ref_clk_in(ref_clk_in),
      .div_val(s.div),
      .clear(full_rst),
      .tick_1m(tick_1m),
      .tick_low(tick_low)
   );

   // One deserializer per channel, each with its own rate select
   // independent channels
   for (genvar c = 0; c < ARX_NCH; c++) begin : g_chan
      assign smp_en[c] = rx_low_speed[c] ? tick_low : tick_1m;
      arx_deser u_deser (
         .clk(clk),
         .reset_n(reset_n),
         .abort(data_rst),
         .smp_en(smp_en[c]),
         .line_one(rx_line_one[c]),
         .line_zero(rx_line_zero[c]),
         .word_valid(rx_valid[c]),
         .word(rx_word[c])
      );
   end

   // Whole state update; reset effects are applied last so they win
   always_comb begin
      n = s;
      n.rd_valid = '0;
      n.loaded = '0;
      n.mb_valid = 1'b0;
      w = '0;
      label_hit = 1'b0;
      sdi_hit = 1'b0;
      load = 1'b0;
      do_rd = 1'b0;
      cnt_v = '0;

      // Pin must stay high for the whole hold time; shorter pulses are
      // ignored, and a pin held longer keeps the block in reset
      // reset sources
      full_rst = full_reset;
      if (hard_reset_pin) begin
         if (s.hr_cnt != HW'(HR_CYC - 1)) begin
            n.hr_cnt = s.hr_cnt + 1'b1;
         end else begin
            full_rst = 1'b1;
         end
      end else begin
         n.hr_cnt = '0;
      end
      data_rst = full_rst | data_only_reset;

      // Divider setting, readable back at any time
      if (clk_div_wr) begin
         n.div = clk_div_val;
      end

      // Label memory is loaded serially from the top label downward
      // label memory load
      if (lbl_load_start) begin
         n.lbl_ptr = ARX_LBL_FIRST;
      end else if (lbl_load_valid) begin
         n.lbl_mem[lbl_load_chan][s.lbl_ptr] = lbl_load_bit;
         n.lbl_ptr = s.lbl_ptr - 8'h01;
      end

      // Match values; index 3 does not exist and is ignored
      if (pl_match_wr && (pl_match_idx < 2'(ARX_NPL))) begin
         n.match[pl_match_chan][pl_match_idx] = pl_match_val;
      end

      // Mailbox read clears its flag; a capture below in the same cycle
      // sets it again, so a new word is never lost
      if (mb_rd && (mb_rd_idx < 2'(ARX_NPL))) begin
         n.mb_data = s.mbox[mb_rd_chan][mb_rd_idx];
         n.mb_valid = 1'b1;
         n.mb_avail[mb_rd_chan][mb_rd_idx] = 1'b0;
      end

      for (int c = 0; c < ARX_NCH; c++) begin
         w = rx_word[c];
         // Parity mark replaces bit 32 only when checking is on
         // odd gives zero
         if (parity_enable[c]) begin
            w.par = ~(^rx_word[c]);
         end

         // Filter settings are live inputs, sampled on every word
         // config any time
         label_hit = s.lbl_mem[c][w.label];
         sdi_hit = (w.sdi == {sdi_expected_high[c], sdi_expected_low[c]});
         load = rx_valid[c] &&
                (!label_filter_enable[c] || label_hit) &&
                (!sdi_filter_enable[c] || sdi_hit);

         // Read first, so a full FIFO read in the same cycle makes room
         do_rd = fifo_rd[c] && (s.cnt[c] != '0);
         cnt_v = s.cnt[c];
         if (do_rd) begin
            n.rd_data[c] = s.fifo[c][s.rp[c]];
            n.rd_valid[c] = 1'b1;
            n.rp[c] = s.rp[c] + 1'b1;
            cnt_v = cnt_v - 1'b1;
         end

         if (load) begin
            n.loaded[c] = 1'b1;
            if (cnt_v == CW'(FIFO_DEPTH)) begin
               n.fifo[c][AW'(s.wp[c] - 1'b1)] = w;
            end else begin
               n.fifo[c][s.wp[c]] = w;
               n.wp[c] = s.wp[c] + 1'b1;
               cnt_v = cnt_v + 1'b1;
            end
         end
         n.cnt[c] = cnt_v;
         n.empty[c] = (cnt_v == '0);
         // Compared at full width: a small FIFO never reaches the level
         n.half[c] = (int'(cnt_v) > ARX_HALF_LVL);
         n.full[c] = (cnt_v == CW'(FIFO_DEPTH));

         // Capture sees every framed word, filtered or not; the label
         // byte is dropped to keep the mailbox at 24 bits
         // word to both paths
         if (rx_valid[c] && priority_label_capture[c]) begin
            for (int k = 0; k < ARX_NPL; k++) begin
               if (w.label == s.match[c][k]) begin
                  n.mbox[c][k] = {w.par, w.ssm, w.data, w.sdi};
                  n.mb_avail[c][k] = 1'b1;
               end
            end
         end
      end

      if (data_rst) begin
         n.wp = '0;
         n.rp = '0;
         n.cnt = '0;
         n.mbox = '0;
         n.mb_avail = '0;
         n.empty = '1;
         n.half = '0;
         n.full = '0;
         n.rd_valid = '0;
         n.rd_data = '0;
         n.loaded = '0;
         n.mb_valid = 1'b0;
         n.mb_data = '0;
      end
      if (full_rst) begin
         n.div = ARX_DIV_RST;
         n.lbl_mem = '0;
         n.lbl_ptr = ARX_LBL_FIRST;
         n.match = '0;
      end
   end

   // Power-on defaults equal the full reset state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
         s.div <= ARX_DIV_RST;
         s.lbl_ptr <= ARX_LBL_FIRST;
         s.empty <= '1;
      end else begin
         s <= n;
      end
   end

   // Outputs straight from the state register
   assign clk_div_rd = s.div;
   assign mb_rd_valid = s.mb_valid;
   assign mb_rd_data = s.mb_data;
   assign mb_avail = s.mb_avail;
   assign fifo_rd_valid = s.rd_valid;
   assign fifo_rd_data = s.rd_data;
   assign fifo_empty = s.empty;
   assign fifo_half = s.half;
   assign fifo_full = s.full;
   assign word_loaded = s.loaded;

endmodule

// file: design/arx_pkg.sv
package arx_pkg;

   // Core clock rate and hard reset pin hold time
   localparam int ARX_CLK_MHZ = 250;
   localparam int ARX_HR_MIN_NS = 1000;
   // Least time rounds up to whole cycles
   localparam int ARX_HR_CYC = (ARX_HR_MIN_NS * ARX_CLK_MHZ + 999) / 1000;

   // Receive path sizes
   localparam int ARX_NCH = 2;
   localparam int ARX_NPL = 3;
   localparam int ARX_FIFO_DEPTH = 32;
   localparam int ARX_HALF_LVL = 16;
   localparam int ARX_WORD_BITS = 32;
   localparam int ARX_LBL_NUM = 256;

   // Sampling: 10 samples per bit, low speed tick is 1 MHz / 8
   localparam int ARX_SMP_PER_BIT = 10;
   localparam int ARX_LOW_SMP_DIV = 8;
   // Null samples that end a word or frame a new one (two bit times)
   localparam int ARX_GAP_SMP = 2 * ARX_SMP_PER_BIT;

   // Values after reset
   localparam logic [3:0] ARX_DIV_RST = 4'h0;
   localparam logic [7:0] ARX_LBL_FIRST = 8'hff;

   // One received word, first bit on the line in bit 0
   typedef struct packed {
      logic par;
      logic [1:0] ssm;
      logic [18:0] data;
      logic [1:0] sdi;
      logic [7:0] label;
   } arx_word_s;

   // Filtered line level and word framing state
   typedef enum logic [1:0] {ARX_NUL, ARX_ONE, ARX_ZER} arx_lvl_e;
   typedef enum logic {ARX_HUNT, ARX_BITS} arx_fr_e;

endpackage

// file: design/arx_refdiv.sv
`timescale 1ns/1ps
module arx_refdiv import arx_pkg::*; #(
   parameter int LOW_DIV = ARX_LOW_SMP_DIV
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Reference clock pin and divider setting
   input wire logic ref_clk_in,
   input wire logic [3:0] div_val,
   input wire logic clear,
   // One-cycle timing enables
   output logic tick_1m,
   output logic tick_low
);

   typedef struct packed {
      logic ref_d;
      logic [4:0] edge_cnt;
      logic [2:0] low_cnt;
      logic tick_1m;
      logic tick_low;
   } arx_div_s;

   arx_div_s s, n;
   logic [4:0] ratio;

   // Zero selects 1 MHz; otherwise the setting is half the ratio
   // reference divide
   always_comb begin
      n = s;
      n.tick_1m = 1'b0;
      n.tick_low = 1'b0;
      ratio = (div_val == 4'h0) ? 5'h01 : {div_val, 1'b0};
      n.ref_d = ref_clk_in;
      if (ref_clk_in && !s.ref_d) begin
         if (s.edge_cnt + 5'h01 >= ratio) begin
            n.edge_cnt = 5'h00;
            n.tick_1m = 1'b1;
            if (s.low_cnt == 3'(LOW_DIV - 1)) begin
               n.low_cnt = 3'h0;
               n.tick_low = 1'b1;
            end else begin
               n.low_cnt = s.low_cnt + 3'h1;
            end
         end else begin
            n.edge_cnt = s.edge_cnt + 5'h01;
         end
      end
      if (clear) begin
         n.edge_cnt = 5'h00;
         n.low_cnt = 3'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign tick_1m = s.tick_1m;
   assign tick_low = s.tick_low;

endmodule

// file: design/arx_deser.sv
`timescale 1ns/1ps
module arx_deser import arx_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic abort,
   // Sample enable and line receiver levels
   input wire logic smp_en,
   input wire logic line_one,
   input wire logic line_zero,
   // Framed word
   output logic word_valid,
   output arx_word_s word
);

   typedef struct packed {
      logic [1:0] h1;
      logic [1:0] h0;
      arx_lvl_e lvl;
      arx_fr_e fr;
      logic [4:0] nul_cnt;
      logic [4:0] bit_cnt;
      logic [31:0] sh;
      logic valid;
      arx_word_s word;
   } arx_des_s;

   arx_des_s s, n;
   arx_lvl_e nl;
   logic line_nul;

   always_comb begin
      n = s;
      n.valid = 1'b0;
      nl = s.lvl;
      line_nul = !line_one && !line_zero;
      if (smp_en) begin
         n.h1 = {s.h1[0], line_one};
         n.h0 = {s.h0[0], line_zero};
         if (line_one && (&s.h1)) begin
            nl = ARX_ONE;
         end else if (line_zero && (&s.h0)) begin
            nl = ARX_ZER;
         end else if (line_nul && !(|s.h1) && !(|s.h0)) begin
            nl = ARX_NUL;
         end
         n.lvl = nl;
         if (nl == ARX_NUL) begin
            if (s.nul_cnt != 5'(ARX_GAP_SMP)) begin
               n.nul_cnt = s.nul_cnt + 5'h01;
            end else begin
               n.fr = ARX_BITS;
               n.bit_cnt = 5'h00;
            end
         end else if (s.lvl == ARX_NUL) begin
            // New pulse: a direct one to zero swap is treated as noise
            n.nul_cnt = 5'h00;
            if (s.fr == ARX_BITS) begin
               n.sh = {(nl == ARX_ONE), s.sh[31:1]};
               n.bit_cnt = s.bit_cnt + 5'h01;
               if (s.bit_cnt == 5'(ARX_WORD_BITS - 1)) begin
                  n.valid = 1'b1;
                  n.word = n.sh;
                  n.fr = ARX_HUNT;
                  n.bit_cnt = 5'h00;
               end
            end
         end
      end
      if (abort) begin
         n = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign word_valid = s.valid;
   assign word = s.word;

endmodule

// file: verification/arx_core_props.sv
`timescale 1ns/1ps
module arx_core_props import arx_pkg::*; #(
   parameter int FIFO_DEPTH = ARX_FIFO_DEPTH,
   parameter int HR_CYC = ARX_HR_CYC
) (
   // Clock and resets
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hard_reset_pin,
   input wire logic full_reset,
   input wire logic data_only_reset,
   // Divider
   input wire logic clk_div_wr,
   input wire logic [3:0] clk_div_val,
   input wire logic [3:0] clk_div_rd,
   // FIFO side
   input wire logic [1:0] fifo_rd,
   input wire logic [1:0] fifo_rd_valid,
   input wire logic [1:0] fifo_empty,
   input wire logic [1:0] fifo_half,
   input wire logic [1:0] fifo_full,
   input wire logic [1:0] word_loaded,
   // Mailbox side
   input wire logic mb_rd,
   input wire logic [1:0] mb_rd_idx,
   input wire logic mb_rd_valid,
   input wire logic [1:0][2:0] mb_avail
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_div_wr;
      clk_div_wr && !full_reset && !hard_reset_pin
         |=> clk_div_rd == $past(clk_div_val);
   endproperty
   a_div_wr: assert property (p_div_wr)
      else $error("divider readback wrong");
   property p_full_rst;
      full_reset |=> clk_div_rd == 4'h0 && fifo_empty == 2'b11
         && mb_avail == 6'h00 && fifo_full == 2'b00;
   endproperty
   a_full_rst: assert property (p_full_rst)
      else $error("full reset left state");
   property p_data_rst;
      data_only_reset && !full_reset && !clk_div_wr && !hard_reset_pin
         |=> $stable(clk_div_rd) && fifo_empty == 2'b11 && mb_avail == 6'h00;
   endproperty
   a_data_rst: assert property (p_data_rst)
      else $error("data reset wrong");
   property p_rd_empty;
      fifo_rd[0] && fifo_empty[0] |=> !fifo_rd_valid[0];
   endproperty
   a_rd_empty: assert property (p_rd_empty)
      else $error("read of empty fifo answered");
   property p_rd_ok;
      fifo_rd[1] && !fifo_empty[1] && !data_only_reset && !full_reset
         && !hard_reset_pin |=> fifo_rd_valid[1];
   endproperty
   a_rd_ok: assert property (p_rd_ok)
      else $error("fifo read not answered");
   property p_valid_cause;
      fifo_rd_valid[0] |-> $past(fifo_rd[0]) && !$past(fifo_empty[0]);
   endproperty
   a_valid_cause: assert property (p_valid_cause)
      else $error("read valid without read");
   property p_mb_valid;
      mb_rd_valid |-> $past(mb_rd) && $past(mb_rd_idx) != 2'd3;
   endproperty
   a_mb_valid: assert property (p_mb_valid)
      else $error("mailbox valid without read");
   property p_flags;
      fifo_full[0] |-> !fifo_empty[0]
         && fifo_half[0] == (FIFO_DEPTH > ARX_HALF_LVL);
   endproperty
   a_flags: assert property (p_flags)
      else $error("fifo flags disagree");

   // Main scenarios reached
   c_loaded: cover property (word_loaded[0]);
   c_full: cover property (fifo_full[0]);
   c_mb: cover property (mb_rd_valid);
endmodule
bind arx_core arx_core_props #(.FIFO_DEPTH(FIFO_DEPTH), .HR_CYC(HR_CYC))
   u_props (.clk, .reset_n, .hard_reset_pin, .full_reset, .data_only_reset,
   .clk_div_wr, .clk_div_val, .clk_div_rd, .fifo_rd, .fifo_rd_valid,
   .fifo_empty, .fifo_half, .fifo_full, .word_loaded, .mb_rd, .mb_rd_idx,
   .mb_rd_valid, .mb_avail);

// file: verification/arx_line_tx.sv
`timescale 1ns/1ps
module arx_line_tx #(
   parameter int HALF = 20
) (
   // Clock and request
   input wire logic clk,
   input wire logic go,
   input wire logic [31:0] word,
   // Line levels, both low is the null level
   output logic one,
   output logic zero,
   output logic busy
);
   initial begin
      one = 1'b0;
      zero = 1'b0;
      busy = 1'b0;
   end
   // Return-to-zero bits, first bit is bit 0
   always begin
      @(posedge clk);
      if (go) begin
         busy <= 1'b1;
         for (int i = 0; i < 32; i++) begin
            one <= word[i];
            zero <= !word[i];
            repeat (HALF) @(posedge clk);
            one <= 1'b0;
            zero <= 1'b0;
            repeat (HALF) @(posedge clk);
         end
         repeat (8 * HALF) @(posedge clk);
         busy <= 1'b0;
      end
   end
endmodule

// file: verification/arx_core_bench.sv
`timescale 1ns/1ps
module arx_core_bench import arx_pkg::*; ;
   // Design inputs
   logic clk, reset_n, hard_reset_pin, full_reset, data_only_reset;
   logic ref_clk_in, clk_div_wr, lbl_load_start, lbl_load_valid;
   logic lbl_load_chan, lbl_load_bit, pl_match_wr, pl_match_chan;
   logic mb_rd, mb_rd_chan;
   logic [1:0] ref_q, pl_match_idx, mb_rd_idx, fifo_rd, go;
   logic [3:0] clk_div_val;
   logic [7:0] pl_match_val;
   logic [1:0] parity_enable, label_filter_enable, sdi_filter_enable;
   logic [1:0] sdi_expected_high, sdi_expected_low, priority_label_capture;
   logic [31:0] tx_word [2];
   // Line model outputs, design outputs and run counters
   wire [1:0] line_one, line_zero, busy;
   logic [3:0] clk_div_rd;
   logic [1:0] fifo_rd_valid, fifo_empty, fifo_half, fifo_full, word_loaded;
   logic mb_rd_valid;
   logic [23:0] mb_rd_data;
   logic [1:0][2:0] mb_avail;
   arx_word_s [1:0] fifo_rd_data;
   int failures, checks, cyc, loads;

   // Small fifo and short pin hold keep the run brief
   arx_core #(.FIFO_DEPTH(4), .HR_CYC(4)) dut (.clk, .reset_n,
      .hard_reset_pin, .full_reset, .data_only_reset, .ref_clk_in,
      .clk_div_wr, .clk_div_val, .clk_div_rd, .rx_line_one(line_one),
      .rx_line_zero(line_zero), .rx_low_speed(2'b10), .parity_enable,
      .label_filter_enable, .sdi_filter_enable, .sdi_expected_high,
      .sdi_expected_low, .priority_label_capture, .lbl_load_start,
      .lbl_load_valid, .lbl_load_chan, .lbl_load_bit, .pl_match_wr,
      .pl_match_chan, .pl_match_idx, .pl_match_val, .mb_rd, .mb_rd_chan,
      .mb_rd_idx, .mb_rd_valid, .mb_rd_data, .mb_avail, .fifo_rd,
      .fifo_rd_valid, .fifo_rd_data, .fifo_empty, .fifo_half, .fifo_full,
      .word_loaded);
   // Channel 1 runs at low speed, eight times slower
   arx_line_tx #(.HALF(20)) u_tx0 (.clk, .go(go[0]), .word(tx_word[0]),
      .one(line_one[0]), .zero(line_zero[0]), .busy(busy[0]));
   arx_line_tx #(.HALF(160)) u_tx1 (.clk, .go(go[1]), .word(tx_word[1]),
      .one(line_one[1]), .zero(line_zero[1]), .busy(busy[1]));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Reference scaled to one tick per four cycles
   always @(posedge clk) begin
      ref_q <= ref_q + 2'd1;
      ref_clk_in <= ref_q[1];
   end
   // Hang guard, and a count of words stored on channel 0
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (word_loaded[0]) loads <= loads + 1;
      if (cyc == 60000) begin
         failures++;
         tally_and_finish;
      end
   end

   task tally_and_finish;
      if (failures == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] par(input logic [31:0] w);
      return {~^w, w[30:0]};
   endfunction
   // All tasks start and end just after a rising edge
   task automatic send(input int c, input logic [31:0] w);
      tx_word[c] <= w;
      go[c] <= 1'b1;
      @(posedge clk);
      go[c] <= 1'b0;
      @(posedge clk);
      while (busy[c]) @(posedge clk);
   endtask
   task automatic rd(input int c, input logic [31:0] exp);
      fifo_rd[c] <= 1'b1;
      @(posedge clk);
      fifo_rd[c] <= 1'b0;
      #1;
      chk(fifo_rd_valid[c], 1'b1);
      chk(fifo_rd_data[c], exp);
      @(posedge clk);
   endtask
   task automatic setdiv(input logic [3:0] v);
      clk_div_wr <= 1'b1;
      clk_div_val <= v;
      @(posedge clk);
      clk_div_wr <= 1'b0;
      #1;
      chk(clk_div_rd, v);
      @(posedge clk);
   endtask
   task automatic pulse_data_reset;
      data_only_reset <= 1'b1;
      @(posedge clk);
      data_only_reset <= 1'b0;
   endtask

   task automatic t_reset;
      chk(clk_div_rd, 4'h0);
      chk(fifo_empty, 2'b11);
      chk(mb_avail, 6'h00);
      setdiv(4'h6);
      setdiv(4'h0);
   endtask
   task automatic t_parity;
      parity_enable <= 2'b01;
      fork
         send(1, 32'h8765_4321);
         begin
            send(0, 32'h1234_56a5);
            send(0, 32'h1234_56a4);
            parity_enable <= 2'b00;
            send(0, 32'hc234_56a5);
         end
      join
      rd(0, par(32'h1234_56a5));
      rd(0, par(32'h1234_56a4));
      rd(0, 32'hc234_56a5);
      rd(1, 32'h8765_4321);
   endtask
   task automatic t_filter;
      lbl_load_start <= 1'b1;
      @(posedge clk);
      lbl_load_start <= 1'b0;
      // First bit loaded belongs to the highest label
      for (int i = 255; i >= 0; i--) begin
         lbl_load_valid <= 1'b1;
         lbl_load_bit <= (i == 8'ha5);
         @(posedge clk);
      end
      lbl_load_valid <= 1'b0;
      label_filter_enable <= 2'b01;
      sdi_filter_enable <= 2'b01;
      sdi_expected_high <= 2'b01;
      pl_match_wr <= 1'b1;
      pl_match_idx <= 2'd2;
      pl_match_val <= 8'h5a;
      priority_label_capture <= 2'b01;
      @(posedge clk);
      pl_match_wr <= 1'b0;
      send(0, 32'h0000_02a5);
      send(0, 32'h0000_01a5);
      send(0, 32'h0001_025a);
      rd(0, 32'h0000_02a5);
      chk(fifo_empty[0], 1'b1);
      chk(mb_avail[0][2], 1'b1);
      mb_rd <= 1'b1;
      mb_rd_idx <= 2'd2;
      @(posedge clk);
      mb_rd <= 1'b0;
      #1;
      chk(mb_rd_valid, 1'b1);
      chk(mb_rd_data, 24'h000102);
      @(posedge clk);
   endtask
   task automatic t_full;
      label_filter_enable <= 2'b00;
      sdi_filter_enable <= 2'b00;
      for (int k = 0; k < 5; k++) send(0, 32'h0000_0100 + k);
      chk(fifo_full[0], 1'b1);
      chk(fifo_half[0], 1'b0);
      for (int k = 0; k < 3; k++) rd(0, 32'h0000_0100 + k);
      rd(0, 32'h0000_0104);
      chk(fifo_empty[0], 1'b1);
   endtask
   task automatic t_resets;
      setdiv(4'h3);
      pulse_data_reset();
      #1;
      chk(clk_div_rd, 4'h3);
      @(posedge clk);
      setdiv(4'h0);
      label_filter_enable <= 2'b01;
      // Abort a word halfway through, once a null gap has framed it
      repeat (100) @(posedge clk);
      fork
         send(0, 32'h0000_00a5);
         begin
            repeat (600) @(posedge clk);
            pulse_data_reset();
         end
      join
      chk(fifo_empty[0], 1'b1);
      send(0, 32'h0000_00a5);
      rd(0, 32'h0000_00a5);
      full_reset <= 1'b1;
      @(posedge clk);
      full_reset <= 1'b0;
      // Fresh gap so the word is framed and only the filter can drop it
      repeat (100) @(posedge clk);
      send(0, 32'h0000_00a5);
      chk(fifo_empty[0], 1'b1);
      setdiv(4'h3);
      hard_reset_pin <= 1'b1;
      repeat (3) @(posedge clk);
      hard_reset_pin <= 1'b0;
      @(posedge clk);
      chk(clk_div_rd, 4'h3);
      hard_reset_pin <= 1'b1;
      repeat (6) @(posedge clk);
      hard_reset_pin <= 1'b0;
      @(posedge clk);
      #1;
      chk(clk_div_rd, 4'h0);
      chk(loads, 32'd10);
   endtask

   initial begin
      {reset_n, hard_reset_pin, full_reset, data_only_reset} = 4'h0;
      {ref_clk_in, clk_div_wr, lbl_load_start, lbl_load_valid} = 4'h0;
      {lbl_load_chan, lbl_load_bit, pl_match_wr, pl_match_chan} = 4'h0;
      {mb_rd, mb_rd_chan, ref_q, pl_match_idx, mb_rd_idx} = 8'h00;
      {fifo_rd, go, clk_div_val, pl_match_val} = 16'h0000;
      {parity_enable, label_filter_enable, sdi_filter_enable} = 6'h00;
      {sdi_expected_high, sdi_expected_low} = 4'h0;
      priority_label_capture = 2'b00;
      tx_word[0] = 32'h0;
      tx_word[1] = 32'h0;
      failures = 0;
      checks = 0;
      cyc = 0;
      loads = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      // Framing needs a long null gap at low speed
      repeat (700) @(posedge clk);
      t_parity();
      t_filter();
      t_full();
      t_resets();
      tally_and_finish;
   end
endmodule
